// ==== clock_calendar_unit_pkg.sv ====
package clock_calendar_unit_pkg;
	// ************************************************************
	// register map, word indices on the plain register port
	// ************************************************************
	localparam logic [2:0] ADDR_CFG = 3'h0;
	localparam logic [2:0] ADDR_PAD = 3'h1;
	localparam logic [2:0] ADDR_ALCFG = 3'h2;
	localparam logic [2:0] ADDR_TWIN = 3'h3;
	localparam logic [2:0] ADDR_AWIN = 3'h4;
	localparam logic [2:0] ADDR_KEY = 3'h5;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CFG_EN_BIT = 15;
	localparam int CFG_UNLOCK_BIT = 13;
	localparam int CFG_SYNC_BIT = 12;
	localparam int CFG_HALF_BIT = 11;
	localparam int CFG_OE_BIT = 10;
	localparam int CFG_PTR_LSB = 8;
	localparam int PAD_SEL_BIT = 1;
	localparam int PAD_BUF_BIT = 0;
	localparam int AL_EN_BIT = 15;
	localparam int AL_CHIME_BIT = 14;
	localparam int AL_MASK_LSB = 10;
	localparam int AL_PTR_LSB = 8;

	// ************************************************************
	// window pointer codes and alarm interval codes
	// ************************************************************
	localparam logic [1:0] PTR_MIN_SEC = 2'h0;
	localparam logic [1:0] PTR_WD_HR = 2'h1;
	localparam logic [1:0] PTR_MTH_DAY = 2'h2;
	localparam logic [1:0] PTR_YEAR = 2'h3;
	localparam logic [3:0] MASK_HALF = 4'h0;
	localparam logic [3:0] MASK_SEC = 4'h1;
	localparam logic [3:0] MASK_10SEC = 4'h2;
	localparam logic [3:0] MASK_MIN = 4'h3;
	localparam logic [3:0] MASK_10MIN = 4'h4;
	localparam logic [3:0] MASK_HOUR = 4'h5;
	localparam logic [3:0] MASK_DAY = 4'h6;
	localparam logic [3:0] MASK_WEEK = 4'h7;
	localparam logic [3:0] MASK_MONTH = 4'h8;
	localparam logic [3:0] MASK_YEAR = 4'h9;

	// ************************************************************
	// calendar fields, index into the time array
	// ************************************************************
	localparam int F_SEC = 0;
	localparam int F_MIN = 1;
	localparam int F_HOUR = 2;
	localparam int F_DAY = 3;
	localparam int F_MONTH = 4;
	localparam int F_YEAR = 5;
	localparam logic [5:0][7:0] FIELD_LO = {8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
	localparam logic [5:0][7:0] FIELD_HI = {8'h99, 8'h12, 8'h31, 8'h23, 8'h59, 8'h59};
	localparam logic [2:0] WDAY_MAX = 3'h6;
	localparam logic [7:0] DAY_RST = 8'h01;
	localparam logic [7:0] MONTH_RST = 8'h01;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int XTAL_HZ = 32768;
	localparam logic [15:0] HALF_TICKS = 16'(XTAL_HZ / 2);
	localparam logic [15:0] SYNC_TICKS = 16'h0020;

	// ************************************************************
	// unlock sequence
	// ************************************************************
	localparam logic [15:0] KEY_FIRST = 16'h0055;
	localparam logic [15:0] KEY_SECOND = 16'h00aa;

	typedef enum logic [1:0] {KEY_IDLE, KEY_ARMED, KEY_OPEN} clock_calendar_unit_key_e;
endpackage

// ==== clock_calendar_unit_bcd_step.sv ====
`timescale 1ns/10ps
module clock_calendar_unit_bcd_step (
	input wire logic [7:0] val_i,
	input wire logic [7:0] lo_i,
	input wire logic [7:0] hi_i,
	output logic [7:0] nxt_o,
	output logic wrap_o
);
	// ************************************************************
	// two digit bcd increment with wrap
	// ************************************************************
	always_comb begin
		wrap_o = (val_i >= hi_i);
		if (wrap_o) begin
			nxt_o = lo_i;
		end else if (val_i[3:0] >= 4'h9) begin
			nxt_o = {val_i[7:4] + 4'h1, 4'h0};
		end else begin
			nxt_o = {val_i[7:4], val_i[3:0] + 4'h1};
		end
	end
endmodule // clock_calendar_unit_bcd_step

// ==== clock_calendar_unit_calendar_ctrl.sv ====
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
// Contract
// - calendar runs only when enabled; enable write needs unlock
// - time window writes only while unlocked
// - sync flag high near rollover ripple
// - half second flag; seconds byte write clears
// - clock pin driven only when output enabled
// - time pointer selects pair, decrements to zero
// - time pointer codes map to field pairs
// - signed trim, times four, added once per minute
// - config register cleared only at power-on
// - source select picks seconds clock or alarm
// - alarm enable self-clears at zero, chime off
// - chime wraps repeat count, else holds zero
// - alarm mask codes select the interval
// - yearly february 29th alarm every four years
// - alarm pointer selects pair, decrements to zero
// - alarm pointer codes map; code three unimplemented
// - repeat counter decrements on each alarm event while nonzero
// - year holds two bcd digits, gated writes
// - month/day bcd layout, gated writes
// - unlock bit settable only right after sequence
// - window reads decrement; writes only high byte
module clock_calendar_unit_calendar_ctrl #(
	parameter logic [15:0] half_ticks_p = clock_calendar_unit_pkg::HALF_TICKS
) (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic [2:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic [1:0] reg_be_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	input wire logic rtc_xtal_i,
	output logic clk_pin_o,
	output logic clk_pin_oe_o,
	output logic alarm_event_o
);
	import clock_calendar_unit_pkg::*;

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic xtal_meta;
		logic xtal_sync;
		logic xtal_prev;
		logic [15:0] pres;
		logic [10:0] adj;
		logic half_phase;
		logic en;
		logic unlock;
		logic oe;
		logic [1:0] tptr;
		logic [7:0] cal;
		logic pad_sel;
		logic pad_buf;
		logic al_en;
		logic chime;
		logic [3:0] alarm_interval_select;
		logic [1:0] aptr;
		logic [7:0] alarm_repeat_count;
		logic [5:0][7:0] tf;
		logic [2:0] wday;
		logic [4:0][7:0] af;
		logic [2:0] awday;
		clock_calendar_unit_key_e key;
		logic [15:0] rdata;
		logic alarm_pulse;
		logic alarm_evt;
		logic pin_level;
	} clock_calendar_unit_state_s;

	clock_calendar_unit_state_s state_reg;
	clock_calendar_unit_state_s state_next;

	logic xtal_edge;
	logic [15:0] step;
	logic [15:0] pres_sum;
	logic half_tick;
	logic sec_tick;
	logic ripple;
	logic [7:0] day_max;
	logic [6:0] inc;
	logic [5:0] wrap;
	logic [5:0][7:0] nxt;
	logic [5:0][7:0] tn;
	logic [2:0] wday_n;

	// ************************************************************
	// timekeeping prescaler with trim
	// ************************************************************
	assign xtal_edge = state_reg.xtal_sync & ~state_reg.xtal_prev;
	// extra or missing count spreads the trim over the next ticks
	always_comb begin
		if ($signed(state_reg.adj) > 11'sd0) begin
			step = 16'h0002;
		end else if ($signed(state_reg.adj) < 11'sd0) begin
			step = 16'h0000;
		end else begin
			step = 16'h0001;
		end
	end
	assign pres_sum = state_reg.pres + step;
	assign half_tick = state_reg.en & xtal_edge & (pres_sum >= half_ticks_p);
	assign sec_tick = half_tick & state_reg.half_phase;
	// window is wide in core cycles so software sees it ahead of the ripple
	assign ripple = state_reg.en & (state_reg.pres >= half_ticks_p - SYNC_TICKS);

	// ************************************************************
	// bcd calendar chain
	// ************************************************************
	function automatic logic [7:0] days_in_month(input logic [7:0] mon, input logic [7:0] yr);
		logic leap;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
			: (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		if (mon == 8'h02) begin
			days_in_month = leap ? 8'h29 : 8'h28;
		end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11) begin
			days_in_month = 8'h30;
		end else begin
			days_in_month = 8'h31;
		end
	endfunction

	assign day_max = days_in_month(state_reg.tf[F_MONTH], state_reg.tf[F_YEAR]);
	assign inc[0] = sec_tick;

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_field
			clock_calendar_unit_bcd_step u_step (
				.val_i(state_reg.tf[gi]),
				.lo_i(FIELD_LO[gi]),
				.hi_i((gi == F_DAY) ? day_max : FIELD_HI[gi]),
				.nxt_o(nxt[gi]),
				.wrap_o(wrap[gi])
			);
			assign inc[gi + 1] = inc[gi] & wrap[gi];
			assign tn[gi] = inc[gi] ? nxt[gi] : state_reg.tf[gi];
		end
	endgenerate

	assign wday_n = ~inc[F_DAY + 1] ? state_reg.wday
		: (state_reg.wday >= WDAY_MAX) ? 3'h0 : state_reg.wday + 3'h1;

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		logic match;
		logic hit;
		logic wr_t;
		logic wr_a;
		match = 1'b0;
		hit = 1'b0;
		wr_t = reg_wr_i & (reg_addr_i == ADDR_TWIN);
		wr_a = reg_wr_i & (reg_addr_i == ADDR_AWIN);
		state_next = state_reg;
		state_next.xtal_meta = rtc_xtal_i;
		state_next.xtal_sync = state_reg.xtal_meta;
		state_next.xtal_prev = state_reg.xtal_sync;
		state_next.alarm_evt = 1'b0;

		if (state_reg.en && xtal_edge) begin
			state_next.pres = half_tick ? pres_sum - half_ticks_p : pres_sum;
			if ($signed(state_reg.adj) > 11'sd0) begin
				state_next.adj = state_reg.adj - 11'h001;
			end else if ($signed(state_reg.adj) < 11'sd0) begin
				state_next.adj = state_reg.adj + 11'h001;
			end
		end
		if (half_tick) begin
			state_next.half_phase = ~state_reg.half_phase;
			state_next.tf = tn;
			state_next.wday = wday_n;
			state_next.alarm_pulse = 1'b0;
		end
		if (inc[F_MIN]) begin
			state_next.adj = {state_reg.cal[7], state_reg.cal, 2'b00};
		end

		// alarm compare against the time about to be stored
		unique case (state_reg.alarm_interval_select)
			MASK_HALF: match = 1'b1;
			MASK_SEC: match = sec_tick;
			MASK_10SEC: match = sec_tick & (tn[F_SEC][3:0] == state_reg.af[F_SEC][3:0]);
			MASK_MIN: match = sec_tick & (tn[F_SEC] == state_reg.af[F_SEC]);
			MASK_10MIN: match = sec_tick & (tn[F_SEC] == state_reg.af[F_SEC])
				& (tn[F_MIN][3:0] == state_reg.af[F_MIN][3:0]);
			MASK_HOUR: match = sec_tick & (tn[1:0] == state_reg.af[1:0]);
			MASK_DAY: match = sec_tick & (tn[2:0] == state_reg.af[2:0]);
			MASK_WEEK: match = sec_tick & (tn[2:0] == state_reg.af[2:0])
				& (wday_n == state_reg.awday);
			MASK_MONTH: match = sec_tick & (tn[3:0] == state_reg.af[3:0]);
			// a feb 29th target only exists in leap years
			MASK_YEAR: match = sec_tick & (tn[4:0] == state_reg.af[4:0]);
			default: match = 1'b0;
		endcase
		hit = half_tick & state_reg.al_en & match;
		if (hit) begin
			state_next.alarm_evt = 1'b1;
			state_next.alarm_pulse = 1'b1;
			if (state_reg.alarm_repeat_count == 8'h00) begin
				if (state_reg.chime) begin
					state_next.alarm_repeat_count = 8'hff;
				end else begin
					state_next.al_en = 1'b0;
				end
			end else begin
				state_next.alarm_repeat_count = state_reg.alarm_repeat_count - 8'h01;
			end
		end

		// unlock window lasts exactly one cycle after the second key
		unique case (state_reg.key)
			KEY_IDLE: state_next.key = KEY_IDLE;
			KEY_ARMED: state_next.key = reg_wr_i ? KEY_IDLE : KEY_ARMED;
			KEY_OPEN: state_next.key = KEY_IDLE;
		endcase
		if (reg_wr_i && reg_addr_i == ADDR_KEY) begin
			if (reg_wdata_i == KEY_FIRST) begin
				state_next.key = KEY_ARMED;
			end else if (reg_wdata_i == KEY_SECOND && state_reg.key == KEY_ARMED) begin
				state_next.key = KEY_OPEN;
			end
		end

		// ************************************************************
		// register writes
		// ************************************************************
		if (reg_wr_i && reg_addr_i == ADDR_CFG) begin
			if (reg_be_i[1]) begin
				if (state_reg.unlock) begin
					state_next.en = reg_wdata_i[CFG_EN_BIT];
				end
				if (!reg_wdata_i[CFG_UNLOCK_BIT] || state_reg.key == KEY_OPEN) begin
					state_next.unlock = reg_wdata_i[CFG_UNLOCK_BIT];
				end
				state_next.oe = reg_wdata_i[CFG_OE_BIT];
				state_next.tptr = reg_wdata_i[CFG_PTR_LSB +: 2];
			end
			if (reg_be_i[0]) begin
				state_next.cal = reg_wdata_i[7:0];
			end
		end
		if (reg_wr_i && reg_addr_i == ADDR_PAD && reg_be_i[0]) begin
			state_next.pad_sel = reg_wdata_i[PAD_SEL_BIT];
			state_next.pad_buf = reg_wdata_i[PAD_BUF_BIT];
		end
		if (reg_wr_i && reg_addr_i == ADDR_ALCFG) begin
			if (reg_be_i[1]) begin
				state_next.al_en = reg_wdata_i[AL_EN_BIT];
				state_next.chime = reg_wdata_i[AL_CHIME_BIT];
				state_next.alarm_interval_select = reg_wdata_i[AL_MASK_LSB +: 4];
				state_next.aptr = reg_wdata_i[AL_PTR_LSB +: 2];
			end
			if (reg_be_i[0]) begin
				state_next.alarm_repeat_count = reg_wdata_i[7:0];
			end
		end
		if (wr_t && state_reg.unlock) begin
			unique case (state_reg.tptr)
				PTR_MIN_SEC: begin
					if (reg_be_i[1]) begin
						state_next.tf[F_MIN] = {1'b0, reg_wdata_i[14:8]};
					end
					if (reg_be_i[0]) begin
						state_next.tf[F_SEC] = {1'b0, reg_wdata_i[6:0]};
						state_next.half_phase = 1'b0;
						state_next.pres = 16'h0000;
					end
				end
				PTR_WD_HR: begin
					if (reg_be_i[1]) begin
						state_next.wday = reg_wdata_i[10:8];
					end
					if (reg_be_i[0]) begin
						state_next.tf[F_HOUR] = {2'b00, reg_wdata_i[5:0]};
					end
				end
				PTR_MTH_DAY: begin
					if (reg_be_i[1]) begin
						state_next.tf[F_MONTH] = {3'b000, reg_wdata_i[12:8]};
					end
					if (reg_be_i[0]) begin
						state_next.tf[F_DAY] = {2'b00, reg_wdata_i[5:0]};
					end
				end
				PTR_YEAR: begin
					if (reg_be_i[0]) begin
						state_next.tf[F_YEAR] = reg_wdata_i[7:0];
					end
				end
			endcase
		end
		if (wr_a) begin
			unique case (state_reg.aptr)
				PTR_MIN_SEC: begin
					if (reg_be_i[1]) begin
						state_next.af[F_MIN] = {1'b0, reg_wdata_i[14:8]};
					end
					if (reg_be_i[0]) begin
						state_next.af[F_SEC] = {1'b0, reg_wdata_i[6:0]};
					end
				end
				PTR_WD_HR: begin
					if (reg_be_i[1] && state_reg.unlock) begin
						state_next.awday = reg_wdata_i[10:8];
					end
					if (reg_be_i[0] && state_reg.unlock) begin
						state_next.af[F_HOUR] = {2'b00, reg_wdata_i[5:0]};
					end
				end
				PTR_MTH_DAY: begin
					if (reg_be_i[1] && state_reg.unlock) begin
						state_next.af[F_MONTH] = {3'b000, reg_wdata_i[12:8]};
					end
					if (reg_be_i[0] && state_reg.unlock) begin
						state_next.af[F_DAY] = {2'b00, reg_wdata_i[5:0]};
					end
				end
				PTR_YEAR: begin
				end
			endcase
		end

		// ************************************************************
		// reads and pointer walk
		// ************************************************************
		state_next.rdata = 16'h0000;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				ADDR_CFG: state_next.rdata = {state_reg.en, 1'b0, state_reg.unlock, ripple,
					state_reg.half_phase, state_reg.oe, state_reg.tptr, state_reg.cal};
				ADDR_PAD: state_next.rdata = {14'h0000, state_reg.pad_sel, state_reg.pad_buf};
				ADDR_ALCFG: state_next.rdata = {state_reg.al_en, state_reg.chime,
					state_reg.alarm_interval_select, state_reg.aptr, state_reg.alarm_repeat_count};
				ADDR_TWIN: begin
					unique case (state_reg.tptr)
						PTR_MIN_SEC: state_next.rdata = {state_reg.tf[F_MIN], state_reg.tf[F_SEC]};
						PTR_WD_HR: state_next.rdata = {5'h00, state_reg.wday, state_reg.tf[F_HOUR]};
						PTR_MTH_DAY: state_next.rdata = {state_reg.tf[F_MONTH], state_reg.tf[F_DAY]};
						PTR_YEAR: state_next.rdata = {8'h00, state_reg.tf[F_YEAR]};
					endcase
				end
				ADDR_AWIN: begin
					unique case (state_reg.aptr)
						PTR_MIN_SEC: state_next.rdata = {state_reg.af[F_MIN], state_reg.af[F_SEC]};
						PTR_WD_HR: state_next.rdata = {5'h00, state_reg.awday, state_reg.af[F_HOUR]};
						PTR_MTH_DAY: state_next.rdata = {state_reg.af[F_MONTH], state_reg.af[F_DAY]};
						PTR_YEAR: state_next.rdata = 16'h0000;
					endcase
				end
				default: state_next.rdata = 16'h0000;
			endcase
		end
		// full word reads hit both bytes, so any read walks the pointer
		if ((reg_rd_i || (wr_t && reg_be_i[1])) && reg_addr_i == ADDR_TWIN
			&& state_reg.tptr != 2'h0) begin
			state_next.tptr = state_reg.tptr - 2'h1;
		end
		if ((reg_rd_i || (wr_a && reg_be_i[1])) && reg_addr_i == ADDR_AWIN
			&& state_reg.aptr != 2'h0) begin
			state_next.aptr = state_reg.aptr - 2'h1;
		end

		// seconds clock is high in the first half of each second
		state_next.pin_level = state_next.pad_sel ? ~state_next.half_phase
			: state_next.alarm_pulse;
	end

	// ************************************************************
	// registers, power-on reset only
	// ************************************************************
	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_reg <= '0;
			state_reg.tf[F_DAY] <= DAY_RST;
			state_reg.tf[F_MONTH] <= MONTH_RST;
			state_reg.af[F_DAY] <= DAY_RST;
			state_reg.af[F_MONTH] <= MONTH_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	assign reg_rdata_o = state_reg.rdata;
	assign clk_pin_o = state_reg.pin_level & state_reg.oe;
	assign clk_pin_oe_o = state_reg.oe;
	assign alarm_event_o = state_reg.alarm_evt;
endmodule // clock_calendar_unit_calendar_ctrl

// ==== clock_calendar_unit_calendar_ctrl_monitor.sv ====
`timescale 1ns/10ps
module clock_calendar_unit_calendar_ctrl_monitor #(
	parameter logic [15:0] half_ticks_p = 16'h4000
) (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic [2:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic [1:0] reg_be_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic rtc_xtal_i,
	input wire logic clk_pin_o,
	input wire logic clk_pin_oe_o,
	input wire logic alarm_event_o
);
	import clock_calendar_unit_pkg::*;
	// ************************************************************
	// port relations
	// ************************************************************
	logic cfg_wr_hi;
	assign cfg_wr_hi = reg_wr_i && (reg_addr_i == ADDR_CFG) && reg_be_i[1];
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	AST_RDATA_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
		else $error("read data not zero outside read answer");
	AST_KEY_READ: assert property (reg_rd_i && reg_addr_i >= ADDR_KEY
		|=> reg_rdata_o == 16'h0000)
		else $error("key or unmapped read not zero");
	AST_CFG_LAYOUT: assert property (reg_rd_i && reg_addr_i == ADDR_CFG
		|=> !reg_rdata_o[14] && (!reg_rdata_o[12] || reg_rdata_o[15]))
		else $error("config read shows bit 14 or sync while stopped");
	AST_PAD_LAYOUT: assert property (reg_rd_i && reg_addr_i == ADDR_PAD
		|=> reg_rdata_o[15:2] == 14'h0)
		else $error("pad config upper bits not zero");
	AST_PIN_GATED: assert property (!clk_pin_oe_o && $past(!clk_pin_oe_o) |-> !clk_pin_o)
		else $error("pin driven while output disabled");
	AST_OE_FOLLOWS: assert property (cfg_wr_hi ##1 !cfg_wr_hi
		|=> clk_pin_oe_o == $past(reg_wdata_i[CFG_OE_BIT], 2))
		else $error("output enable not taken from config write");
	AST_OE_HOLD: assert property ($changed(clk_pin_oe_o) |-> $past(cfg_wr_hi) || $past(cfg_wr_hi, 2))
		else $error("output enable changed without config write");
	AST_EVENT_PULSE: assert property (alarm_event_o |=> !alarm_event_o [*8])
		else $error("alarm event longer than one cycle or too close");
endmodule // clock_calendar_unit_calendar_ctrl_monitor

bind clock_calendar_unit_calendar_ctrl clock_calendar_unit_calendar_ctrl_monitor #(.half_ticks_p(half_ticks_p)) u_monitor (
	.core_clk_i(core_clk_i),
	.reset_i(reset_i),
	.reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i),
	.reg_be_i(reg_be_i),
	.reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o),
	.rtc_xtal_i(rtc_xtal_i),
	.clk_pin_o(clk_pin_o),
	.clk_pin_oe_o(clk_pin_oe_o),
	.alarm_event_o(alarm_event_o)
);

// ==== tb_clock_calendar_unit_calendar_ctrl.sv ====
`timescale 1ns/10ps
module tb_clock_calendar_unit_calendar_ctrl;
	import clock_calendar_unit_pkg::*;
	// ************************************************************
	// stimulus and model state
	// ************************************************************
	// short half second keeps the run small; must stay above the sync window
	localparam logic [15:0] HALF_P = 16'h0080;
	localparam int SEC_CYC = 2048;
	logic core_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [2:0] reg_addr_i = 3'h0;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic [1:0] reg_be_i = 2'h0;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic rtc_xtal_i = 1'b0;
	logic [15:0] reg_rdata_o;
	logic clk_pin_o;
	logic clk_pin_oe_o;
	logic alarm_event_o;
	int failures = 0;
	int check_count = 0;
	int ev_cnt = 0;
	int ev_base;
	int i;
	logic [15:0] v;
	logic [15:0] tw [4] = '{16'h0000, 16'h0000, 16'h0101, 16'h0000};
	logic [15:0] tw_mask [4] = '{16'h7f7f, 16'h073f, 16'h1f3f, 16'h00ff};
	logic [1:0] tptr = 2'h0;
	logic [7:0] cfg_hi = 8'h00;

	clock_calendar_unit_calendar_ctrl #(.half_ticks_p(HALF_P)) u_dut (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i),
		.reg_be_i(reg_be_i),
		.reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o),
		.rtc_xtal_i(rtc_xtal_i),
		.clk_pin_o(clk_pin_o),
		.clk_pin_oe_o(clk_pin_oe_o),
		.alarm_event_o(alarm_event_o)
	);

	initial begin
		forever #12.5 core_clk_i = ~core_clk_i;
	end
	// odd offset keeps the crystal edges away from core edges
	initial begin
		#7;
		forever #100 rtc_xtal_i = ~rtc_xtal_i;
	end
	always @(negedge core_clk_i) begin
		if (alarm_event_o === 1'b1) ev_cnt++;
	end
	// ************************************************************
	// bus tasks and model
	// ************************************************************
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// strobe stays up so back-to-back writes assign it once per step
	task automatic wr(input logic [2:0] a, input logic [15:0] d, input logic [1:0] be);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_be_i <= be;
		reg_rd_i <= 1'b0;
		reg_wr_i <= 1'b1;
		@(posedge core_clk_i);
	endtask
	task automatic rd(input logic [2:0] a, input logic [15:0] exp, input logic [15:0] m);
		reg_addr_i <= a;
		reg_wr_i <= 1'b0;
		reg_rd_i <= 1'b1;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		@(negedge core_clk_i);
		check(reg_rdata_o & m, exp & m);
		@(posedge core_clk_i);
	endtask
	task automatic idle(input int n);
		reg_wr_i <= 1'b0;
		reg_rd_i <= 1'b0;
		repeat (n) @(posedge core_clk_i);
	endtask
	task automatic cfgw(input logic [7:0] h);
		cfg_hi = h;
		tptr = h[1:0];
		wr(ADDR_CFG, {h, 8'h00}, 2'b10);
	endtask
	task automatic twr(input logic [15:0] d, input logic [1:0] be);
		wr(ADDR_TWIN, d, be);
		if (cfg_hi[5] && be[0]) tw[tptr][7:0] = d[7:0] & tw_mask[tptr][7:0];
		if (cfg_hi[5] && be[1]) tw[tptr][15:8] = d[15:8] & tw_mask[tptr][15:8];
		if (be[1] && tptr != 2'h0) tptr--;
	endtask
	task automatic trd();
		rd(ADDR_TWIN, tw[tptr], 16'hffff);
		if (tptr != 2'h0) tptr--;
	endtask
	task automatic key();
		wr(ADDR_KEY, KEY_FIRST, 2'b11);
		wr(ADDR_KEY, KEY_SECOND, 2'b11);
	endtask
	initial begin
		repeat (40000) @(posedge core_clk_i);
		failures++;
		end_sim();
	end
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		v = 16'($urandom(32'h6d0a));
		repeat (2) @(posedge core_clk_i);
		reset_i <= 1'b0;
		for (i = 0; i < 8; i++) rd(3'(i), 16'h0000, 16'hffff);
		wr(ADDR_CFG, 16'h8000, 2'b10);
		rd(ADDR_CFG, 16'h0000, 16'hffff);
		twr(16'h1234, 2'b11);
		trd();
		wr(ADDR_CFG, 16'h2000, 2'b10);
		rd(ADDR_CFG, 16'h0000, 16'hffff);
		key();
		wr(ADDR_PAD, 16'h0000, 2'b11);
		wr(ADDR_CFG, 16'h2000, 2'b10);
		rd(ADDR_CFG, 16'h0000, 16'hffff);
		key();
		cfgw(8'h23);
		rd(ADDR_CFG, 16'h2300, 16'hffff);
		v = {8'h12, 4'($urandom % 10), 4'($urandom % 10)};
		twr(v, 2'b11);
		twr(16'h0229, 2'b11);
		twr(16'h0313, 2'b11);
		twr(16'h5958, 2'b11);
		cfgw(8'h21);
		// low byte write must leave the pointer alone
		twr(16'h0014, 2'b01);
		rd(ADDR_CFG, 16'h2100, 16'hffff);
		cfgw(8'h23);
		repeat (5) trd();
		v = 16'($urandom);
		wr(ADDR_CFG, v, 2'b01);
		rd(ADDR_CFG, {cfg_hi[7:2], tptr, v[7:0]}, 16'hffff);
		wr(ADDR_CFG, 16'h0000, 2'b01);
		for (i = 0; i < 10; i++) begin
			v = {2'b00, 4'(i), 2'b00, 8'($urandom)};
			wr(ADDR_ALCFG, v, 2'b11);
			rd(ADDR_ALCFG, v, 16'hffff);
		end
		wr(ADDR_ALCFG, 16'h0300, 2'b11);
		rd(ADDR_AWIN, 16'h0000, 16'hffff);
		wr(ADDR_AWIN, 16'h1231, 2'b11);
		wr(ADDR_AWIN, 16'h0622, 2'b11);
		wr(ADDR_AWIN, 16'h3030, 2'b11);
		wr(ADDR_ALCFG, 16'h0200, 2'b11);
		rd(ADDR_AWIN, 16'h1231, 16'hffff);
		rd(ADDR_AWIN, 16'h0622, 16'hffff);
		rd(ADDR_AWIN, 16'h3030, 16'hffff);
		rd(ADDR_ALCFG, 16'h0000, 16'hffff);
		// run: half second alarm with two repeats, seconds clock on the pin
		wr(ADDR_ALCFG, 16'h8002, 2'b11);
		wr(ADDR_PAD, 16'h0002, 2'b11);
		cfgw(8'ha4);
		twr(16'h5958, 2'b11);
		ev_base = ev_cnt;
		idle(SEC_CYC * 11 / 4);
		tw[0] = 16'h0000;
		trd();
		rd(ADDR_CFG, 16'h0800, 16'h0800);
		check(16'(ev_cnt - ev_base), 16'h0003);
		check({14'h0, clk_pin_oe_o, clk_pin_o}, 16'h0002);
		rd(ADDR_ALCFG, 16'h0000, 16'hfcff);
		twr(16'h0005, 2'b01);
		rd(ADDR_CFG, 16'h0000, 16'h1800);
		idle(4);
		check({14'h0, clk_pin_oe_o, clk_pin_o}, 16'h0003);
		wr(ADDR_ALCFG, 16'hc000, 2'b11);
		idle(1);
		for (i = 0; i < 1200 && alarm_event_o !== 1'b1; i++) @(negedge core_clk_i);
		if (i == 1200) begin
			failures++;
			end_sim();
		end
		@(posedge core_clk_i);
		rd(ADDR_ALCFG, 16'hc0ff, 16'hc0ff);
		// about 112 crystal edges into the half second, inside the ripple window
		idle(900);
		rd(ADDR_CFG, 16'h1000, 16'h1000);
		wr(ADDR_ALCFG, 16'h0000, 2'b11);
		cfgw(8'h24);
		twr(16'h1020, 2'b11);
		idle(SEC_CYC);
		trd();
		cfgw(8'h04);
		twr(16'h0101, 2'b11);
		trd();
		wr(ADDR_CFG, 16'h8400, 2'b10);
		rd(ADDR_CFG, 16'h0400, 16'hffff);
		reset_i <= 1'b1;
		idle(2);
		reset_i <= 1'b0;
		rd(ADDR_CFG, 16'h0000, 16'hffff);
		end_sim();
	end
endmodule // tb_clock_calendar_unit_calendar_ctrl
